// ### rtl/ext_pin_irq_request_flags.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "pin_irq_map.svh"
module ext_pin_irq_request_flags (
  input  wire logic        ref_clk,          // system clock 100 MHz
  input  wire logic        reset_n,          // sync active-low reset
  input  wire logic        power_on_reset,   // power-on reset pulse
  input  wire logic        wdt_sp_reset,     // watchdog/stack-pointer reset pulse
  input  wire logic        ce_reset,         // chip-enable reset pulse
  input  wire logic        clock_stop,       // clock stop pulse
  input  wire logic        ce_counter_run,   // ce reset counter operating
  input  wire logic        ext_irq_pin_zero, // external pin zero
  input  wire logic        ext_irq_pin_one,  // external pin one
  input  wire logic        ce_pin,           // chip-enable pin
  input  wire logic [7:0]  s_axi_awaddr,     // write address
  input  wire logic        s_axi_awvalid,    // write address valid
  output logic             s_axi_awready,    // write address ready
  input  wire logic [31:0] s_axi_wdata,      // write data
  input  wire logic [3:0]  s_axi_wstrb,      // write strobes
  input  wire logic        s_axi_wvalid,     // write data valid
  output logic             s_axi_wready,     // write data ready
  output logic [1:0]       s_axi_bresp,      // write response
  output logic             s_axi_bvalid,     // write response valid
  input  wire logic        s_axi_bready,     // write response ready
  input  wire logic [7:0]  s_axi_araddr,     // read address
  input  wire logic        s_axi_arvalid,    // read address valid
  output logic             s_axi_arready,    // read address ready
  output logic [31:0]      s_axi_rdata,      // read data
  output logic [1:0]       s_axi_rresp,      // read response
  output logic             s_axi_rvalid,     // read data valid
  input  wire logic        s_axi_rready,     // read data ready
  output logic             irq_q             // level interrupt
);
  localparam int NSRC = `IRQ_STATUS_W;

  logic                     aw_have_q;
  logic                     w_have_q;
  logic [7:0]               aw_addr_q;
  logic [31:0]              w_data_q;
  logic [3:0]               w_strb_q;
  logic                     wr_fire;
  logic [NSRC-1:0]          sw_clear;
  logic [NSRC-1:0]          flag;
  logic [NSRC-1:0]          level;
  logic [NSRC-1:0]          pins;
  logic [NSRC-1:0]          flag_prev_q;
  logic [NSRC-1:0]          status_q;
  logic [NSRC-1:0]          mask_q;
  logic [NSRC-1:0]          edge_sel_q;
  logic                     counter_q;
  logic                     hard_clear;
  logic [31:0]              rd_word;
  logic                     rd_ok;
  logic                     wr_ok;
  pin_irq_pkg::nibble_t     reg_pin_zero;
  pin_irq_pkg::nibble_t     reg_pin_one;
  pin_irq_pkg::nibble_t     reg_ce;

  assign hard_clear = power_on_reset | wdt_sp_reset;
  assign pins[pin_irq_pkg::src_pin_zero]    = ext_irq_pin_zero;
  assign pins[pin_irq_pkg::src_pin_one]     = ext_irq_pin_one;
  assign pins[pin_irq_pkg::src_chip_enable] = ce_pin;

  // write: accept address and data in either order
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok = 1'b1;
    unique case (aw_addr_q)
      `PIN_ONE_REQ_ADDR, `PIN_ZERO_REQ_ADDR, `CE_REQ_ADDR,
      `IRQ_STATUS_ADDR, `IRQ_MASK_ADDR, `EDGE_SEL_ADDR: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software clear of a request flag: write 0 to bit 0, lane 0
  always_comb begin
    sw_clear = '0;
    if (wr_fire && w_strb_q[0] && !w_data_q[`REQ_FLAG_BIT]) begin
      sw_clear[pin_irq_pkg::src_pin_zero]    = (aw_addr_q == `PIN_ZERO_REQ_ADDR);
      sw_clear[pin_irq_pkg::src_pin_one]     = (aw_addr_q == `PIN_ONE_REQ_ADDR);
      sw_clear[pin_irq_pkg::src_chip_enable] = (aw_addr_q == `CE_REQ_ADDR);
    end
  end

  for (genvar i = 0; i < NSRC; i++) begin : g_src
    pin_edge_flag u_flag (
      .ref_clk    (ref_clk),
      .reset_n    (reset_n),
      .hard_clear (hard_clear),
      .pin        (pins[i]),
      .rise_sel   (edge_sel_q[i]),
      .sw_clear   (sw_clear[i]),
      .flag_q     (flag[i]),
      .level_q    (level[i])
    );
  end

  // counter bit follows the input, forced 0 on any of the four conditions
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      counter_q <= 1'b0;
    end else if (hard_clear | ce_reset | clock_stop) begin
      counter_q <= 1'b0;
    end else begin
      counter_q <= ce_counter_run;
    end
  end

  // config registers and interrupt status
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mask_q     <= `IRQ_MASK_RESET;
      edge_sel_q <= `EDGE_SEL_RESET;
    end else if (wr_fire && w_strb_q[0]) begin
      if (aw_addr_q == `IRQ_MASK_ADDR) begin
        mask_q <= w_data_q[NSRC-1:0];
      end
      if (aw_addr_q == `EDGE_SEL_ADDR) begin
        edge_sel_q <= w_data_q[NSRC-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flag_prev_q <= '0;
      status_q    <= `IRQ_STATUS_RESET;
    end else begin
      flag_prev_q <= flag;
      // a new request wins over a write-one clear in the same cycle
      if (wr_fire && w_strb_q[0] && aw_addr_q == `IRQ_STATUS_ADDR) begin
        status_q <= (status_q & ~w_data_q[NSRC-1:0]) | (flag & ~flag_prev_q);
      end else begin
        status_q <= status_q | (flag & ~flag_prev_q);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // register images
  assign reg_pin_one  = {level[pin_irq_pkg::src_pin_one], 2'b00, flag[pin_irq_pkg::src_pin_one]};
  assign reg_pin_zero = {level[pin_irq_pkg::src_pin_zero], 2'b00, flag[pin_irq_pkg::src_pin_zero]};
  assign reg_ce       = {level[pin_irq_pkg::src_chip_enable], 1'b0, counter_q,
                         flag[pin_irq_pkg::src_chip_enable]};

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      `PIN_ONE_REQ_ADDR:  rd_word = {28'h0000000, reg_pin_one};
      `PIN_ZERO_REQ_ADDR: rd_word = {28'h0000000, reg_pin_zero};
      `CE_REQ_ADDR:       rd_word = {28'h0000000, reg_ce};
      `IRQ_STATUS_ADDR:   rd_word = {29'h0000000, status_q};
      `IRQ_MASK_ADDR:     rd_word = {29'h0000000, mask_q};
      `EDGE_SEL_ADDR:     rd_word = {29'h0000000, edge_sel_q};
      default:            rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // flag, counter, level, status and interrupt checks
  chk_flag_hard_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hard_clear |=> !flag[pin_irq_pkg::src_pin_zero] && !flag[pin_irq_pkg::src_pin_one])
    else $error("pin flag survived hard reset");
  chk_ce_flag_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hard_clear |=> !reg_ce[0])
    else $error("ce flag survived hard reset");
  chk_ce_keep_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ce_reset && !hard_clear && !sw_clear[2]) |=> $past(flag[2]) <= flag[2])
    else $error("ce flag lost on ce reset");
  chk_counter_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ce_reset || clock_stop) |=> !counter_q)
    else $error("counter bit not cleared");
  chk_counter_hard: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hard_clear |=> !counter_q)
    else $error("counter bit kept on hard reset");
  chk_counter_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ce_counter_run && !hard_clear && !ce_reset && !clock_stop) |=> reg_ce[1])
    else $error("counter bit not shown");
  chk_fixed_zeros: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_pin_one[2:1] == 2'b00 && reg_pin_zero[2:1] == 2'b00 && !reg_ce[2])
    else $error("fixed bits nonzero");
  chk_rdata_upper: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0000000)
    else $error("read data upper bits nonzero");
  chk_level_live: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 reg_pin_one[3] == $past(ext_irq_pin_one) && reg_pin_zero[3] == $past(ext_irq_pin_zero))
    else $error("pin level bit stale");
  chk_ce_level_live: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 reg_ce[3] == $past(ce_pin))
    else $error("ce level bit stale");
  chk_sw_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sw_clear[1] && pins[1] == level[1]) |=> !flag[1])
    else $error("software clear ignored");
  chk_clear_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sw_clear[0] && $stable(ext_irq_pin_zero)) |=> !flag[0])
    else $error("pin zero clear ignored");
  chk_ce_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sw_clear[2] && $stable(ce_pin)) |=> !flag[2])
    else $error("ce clear ignored");
  chk_rise_sets: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (edge_sel_q[0] && !hard_clear && $rose(ext_irq_pin_zero)) |-> ##1 flag[0])
    else $error("edge did not set flag");
  chk_fall_sets: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!edge_sel_q[1] && !hard_clear && $fell(ext_irq_pin_one)) |=> flag[1])
    else $error("falling edge did not set flag");
  chk_ce_rise_sets: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (edge_sel_q[2] && !hard_clear && $rose(ce_pin)) |=> flag[2])
    else $error("ce edge did not set flag");
  chk_flag_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (flag[0] && !hard_clear && !sw_clear[0]) |=> flag[0])
    else $error("pin zero flag dropped");
  chk_no_spurious: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!flag[1] && $stable(ext_irq_pin_one)) |=> !flag[1])
    else $error("flag set without edge");
  chk_status_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (flag[0] && !flag_prev_q[0]) |=> status_q[0])
    else $error("status bit not set");
  chk_status_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_fire && w_strb_q[0] && aw_addr_q == `IRQ_STATUS_ADDR && w_data_q[0]
     && !(flag[0] && !flag_prev_q[0])) |=> !status_q[0])
    else $error("status bit not cleared");
  chk_irq_level: assert property (@(posedge ref_clk) disable iff (!reset_n)
    |(status_q & mask_q) |=> irq_q)
    else $error("interrupt not raised");
  chk_irq_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(|(status_q & mask_q)) |=> !irq_q)
    else $error("interrupt not dropped");

  // bus handshake checks
  chk_awready_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  chk_wready_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_wready |=> !s_axi_wready)
    else $error("wready held");
  chk_arready_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_arready |=> !s_axi_arready)
    else $error("arready held");
  chk_bvalid_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_rvalid_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_read_overlap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_write_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_fire |=> s_axi_bvalid)
    else $error("write not answered");
  chk_write_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_fire |=> !wr_fire)
    else $error("write applied twice");
  chk_bad_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_fire && !wr_ok) |=> s_axi_bresp == `AXI_RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_bad_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (s_axi_arvalid && s_axi_arready && !rd_ok) |=> s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule

// ### pkg/pin_irq_map.svh
`ifndef PIN_IRQ_MAP_SVH
`define PIN_IRQ_MAP_SVH
// register-file indices; byte address is four times the index
`define PIN_ONE_REQ_IDX   6'h3D
`define PIN_ZERO_REQ_IDX  6'h3E
`define CE_REQ_IDX        6'h3F
`define PIN_ONE_REQ_ADDR  8'hF4
`define PIN_ZERO_REQ_ADDR 8'hF8
`define CE_REQ_ADDR       8'hFC
`define IRQ_STATUS_ADDR   8'h00
`define IRQ_MASK_ADDR     8'h04
`define EDGE_SEL_ADDR     8'h08
// field positions
`define REQ_FLAG_BIT      0
`define CE_COUNTER_BIT    1
`define PIN_LEVEL_BIT     3
`define IRQ_STATUS_W      3
`define IRQ_STATUS_RESET  3'h0
`define IRQ_MASK_RESET    3'h0
`define EDGE_SEL_RESET    3'h7
// axi responses
`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2
`endif

// ### pkg/pin_irq_pkg.sv
package pin_irq_pkg;
  typedef enum logic [1:0] {
    src_pin_zero,
    src_pin_one,
    src_chip_enable
  } irq_src_t;
  typedef logic [3:0] nibble_t;
endpackage

// ### rtl/pin_edge_flag.sv
`timescale 1ns/10ps
// one request source: edge detect on a synchronous pin, sticky flag
module pin_edge_flag (
  input  wire logic ref_clk,       // system clock
  input  wire logic reset_n,       // sync active-low reset
  input  wire logic hard_clear,    // power-on or watchdog/stack-pointer reset pulse
  input  wire logic pin,           // pin level
  input  wire logic rise_sel,      // 1 rising, 0 falling active edge
  input  wire logic sw_clear,      // software clear pulse
  output logic      flag_q,        // sticky request flag
  output logic      level_q        // registered pin level
);
  logic prev_q;
  logic hit;

  assign hit = rise_sel ? (pin & ~prev_q) : (~pin & prev_q);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      // start from the pin's own level so a pin idling high gives no false edge after reset
      prev_q  <= pin;
      level_q <= 1'b0;
    end else begin
      prev_q  <= pin;
      level_q <= pin;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
    end else if (hard_clear) begin
      flag_q <= 1'b0;
    end else if (hit) begin
      flag_q <= 1'b1;
    end else if (sw_clear) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// ### test/pin_side.sv
`timescale 1ns/10ps
// far side: drives the two interrupt pins and the chip-enable pin
module pin_side (
  input  wire logic       ref_clk,          // system clock
  input  wire logic [2:0] lvl_req,          // wanted levels: ce, one, zero
  output logic            ext_irq_pin_zero, // external pin zero
  output logic            ext_irq_pin_one,  // external pin one
  output logic            ce_pin            // chip-enable pin
);
  // pins move only after an edge, so every transition is a clean synchronous edge
  always @(posedge ref_clk) {ce_pin, ext_irq_pin_one, ext_irq_pin_zero} <= lvl_req;
endmodule

// ### test/tb.sv
`timescale 1ns/10ps
`include "pin_irq_map.svh"
module tb;
  logic ref_clk = 0, reset_n = 0, por = 0, wdt = 0, cer = 0, cstop = 0, crun = 0;
  logic [2:0] lvl = 3'h0;
  logic p0, p1, pce, awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0, awr, wr, arr, irq_q;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] ws = 4'hF;
  logic [1:0] bresp, rresp, resp;
  int n_mismatch = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  pin_side pin_side_inst (.ref_clk(ref_clk), .lvl_req(lvl), .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1),
    .ce_pin(pce));
  ext_pin_irq_request_flags ext_pin_irq_request_flags_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .power_on_reset(por), .wdt_sp_reset(wdt), .ce_reset(cer), .clock_stop(cstop), .ce_counter_run(crun),
    .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1), .ce_pin(pce), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .irq_q(irq_q));
  task stop_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task guard(input int i);
    if (i > 50) begin
      n_mismatch++;
      stop_test;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic aw_hs, w_hs, aw_done, w_done, b_seen;
    aw_done = 0;
    w_done = 0;
    b_seen = 0;
    @(posedge ref_clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    br <= 1;
    for (i = 0; !(aw_done && w_done && b_seen); i++) begin
      #1;
      aw_hs = awv && awr;
      w_hs = wv && wr;
      b_seen = bv;
      resp = bresp;
      @(posedge ref_clk);
      if (aw_hs) begin awv <= 0; aw_done = 1; end
      if (w_hs) begin wv <= 0; w_done = 1; end
      if (b_seen) br <= 0;
      guard(i);
    end
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d);
    int i;
    logic ar_hs, r_seen;
    r_seen = 0;
    @(posedge ref_clk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    for (i = 0; !r_seen; i++) begin
      #1;
      ar_hs = arv && arr;
      r_seen = rv;
      d = rd;
      resp = rresp;
      @(posedge ref_clk);
      if (ar_hs) arv <= 0;
      if (r_seen) rr <= 0;
      guard(i);
    end
  endtask
  task rd_chk(input logic [7:0] a, input logic [3:0] exp);
    logic [31:0] d;
    axi_rd(a, d);
    chk("rdata", d, {28'h0, exp});
    chk("rresp", {30'h0, resp}, {30'h0, `AXI_RESP_OKAY});
  endtask
  task t_reset;
    rd_chk(`PIN_ONE_REQ_ADDR, 4'h0);
    rd_chk(`PIN_ZERO_REQ_ADDR, 4'h0);
    rd_chk(`CE_REQ_ADDR, 4'h0);
    rd_chk(`EDGE_SEL_ADDR, 4'h7);
  endtask
  task t_edge;
    lvl <= 3'h7;
    tick(3);
    rd_chk(`PIN_ONE_REQ_ADDR, 4'h9);
    rd_chk(`PIN_ZERO_REQ_ADDR, 4'h9);
    rd_chk(`CE_REQ_ADDR, 4'h9);
  endtask
  task t_irq;
    logic [31:0] d;
    chk("irq", {31'h0, irq_q}, 32'h0);
    axi_wr(`IRQ_MASK_ADDR, 32'h7);
    tick(2);
    chk("irq", {31'h0, irq_q}, 32'h1);
    axi_wr(`IRQ_STATUS_ADDR, 32'h7);
    tick(2);
    chk("irq", {31'h0, irq_q}, 32'h0);
    axi_rd(8'h40, d);
    chk("unmapped", d, 32'h0);
    chk("unmapped resp", {30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
  endtask
  task t_clear;
    axi_wr(`PIN_ONE_REQ_ADDR, 32'hF);
    chk("bresp", {30'h0, resp}, {30'h0, `AXI_RESP_OKAY});
    rd_chk(`PIN_ONE_REQ_ADDR, 4'h9);
    axi_wr(`PIN_ONE_REQ_ADDR, 32'h0);
    rd_chk(`PIN_ONE_REQ_ADDR, 4'h8);
  endtask
  task t_hold;
    crun <= 1;
    tick(3);
    rd_chk(`CE_REQ_ADDR, 4'hB);
    cer <= 1;
    rd_chk(`CE_REQ_ADDR, 4'h9);
    rd_chk(`PIN_ZERO_REQ_ADDR, 4'h9);
    cer <= 0;
    cstop <= 1;
    rd_chk(`CE_REQ_ADDR, 4'h9);
    cstop <= 0;
    por <= 1;
    tick(2);
    por <= 0;
    tick(2);
    rd_chk(`PIN_ZERO_REQ_ADDR, 4'h8);
    rd_chk(`CE_REQ_ADDR, 4'hA);
    lvl <= 3'h0;
    tick(3);
    lvl <= 3'h7;
    tick(3);
    rd_chk(`PIN_ONE_REQ_ADDR, 4'h9);
    wdt <= 1;
    tick(2);
    wdt <= 0;
    rd_chk(`PIN_ONE_REQ_ADDR, 4'h8);
  endtask
  task t_fall;
    axi_wr(`EDGE_SEL_ADDR, 32'h0);
    chk("bresp", {30'h0, resp}, {30'h0, `AXI_RESP_OKAY});
    lvl <= 3'h6;
    tick(3);
    rd_chk(`PIN_ZERO_REQ_ADDR, 4'h1);
    rd_chk(`PIN_ONE_REQ_ADDR, 4'h8);
    ws <= 4'h0;
    axi_wr(`PIN_ZERO_REQ_ADDR, 32'h0);
    ws <= 4'hF;
    rd_chk(`PIN_ZERO_REQ_ADDR, 4'h1);
    axi_wr(8'h40, 32'h0);
    chk("unmapped bresp", {30'h0, resp}, {30'h0, `AXI_RESP_SLVERR});
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1;
    t_reset;
    t_edge;
    t_irq;
    t_clear;
    t_hold;
    t_fall;
    stop_test;
  end
endmodule
